// ### include/rx_ctrl_pkg.sv
// Purpose: Shared constants and types for the receive control bank
// Assumes: Wishbone register index is byte address / 4
// Notes:   Register data is 8 bits in the low lane of a 32-bit word
package rx_ctrl_pkg;
    localparam int ADR_W = 8;
    localparam int IDX_W = 6;
    localparam logic [IDX_W-1:0] IDX_CORR_CTRL = 6'h1a;
    localparam logic [IDX_W-1:0] IDX_CORR_HI   = 6'h1b;
    localparam logic [IDX_W-1:0] IDX_CORR_LO   = 6'h1c;
    localparam logic [IDX_W-1:0] IDX_FEI_HI    = 6'h1d;
    localparam logic [IDX_W-1:0] IDX_FEI_LO    = 6'h1e;
    localparam logic [IDX_W-1:0] IDX_PRE_CFG   = 6'h1f;
    localparam logic [IDX_W-1:0] IDX_TO_RSSI   = 6'h20;
    localparam logic [IDX_W-1:0] IDX_TO_PRE    = 6'h21;
    localparam logic [IDX_W-1:0] IDX_TO_SYNC   = 6'h22;
    localparam logic [IDX_W-1:0] IDX_RST_DLY   = 6'h23;
    localparam logic [IDX_W-1:0] IDX_RST_SEL   = 6'h27;
    localparam logic [IDX_W-1:0] IDX_RX_CTRL   = 6'h30;
    localparam logic [IDX_W-1:0] IDX_IRQ_STAT  = 6'h31;
    localparam logic [IDX_W-1:0] IDX_IRQ_MASK  = 6'h32;
    // Field positions
    localparam int CTRL_AGC_BIT   = 4;
    localparam int CTRL_RSVD_BIT  = 3;
    localparam int CTRL_CLR_BIT   = 1;
    localparam int CTRL_AUTOZ_BIT = 0;
    localparam int PRE_EN_BIT     = 7;
    localparam int PRE_LEN_LSB    = 5;
    localparam int RST_SEL_LSB    = 6;
    localparam int RX_EN_BIT      = 0;
    localparam int AUTO_CORR_BIT  = 1;
    // Reset values
    localparam logic [7:0] PRE_CFG_RST = 8'haa;
    localparam logic [1:0] RST_SEL_RST = 2'h2;
    // Receiver restart selections and reserved finder length
    localparam logic [1:0] RESTART_OFF    = 2'h0;
    localparam logic [1:0] RESTART_NOLOCK = 2'h1;
    localparam logic [1:0] RESTART_LOCK   = 2'h2;
    localparam logic [1:0] PRE_LEN_RSVD   = 2'h3;
    // Timing units in bit periods and chips
    localparam int TIMEOUT_UNIT_BITS = 16;
    localparam int DELAY_UNIT_BITS   = 4;
    localparam int CHIPS_PER_BIT     = 4;
    localparam int BITS_PER_BYTE     = 8;
    localparam int BIT_CYCLES_DFLT   = 1000;
    // Interrupt status layout
    localparam int IRQ_W       = 5;
    localparam int IRQ_PREAMBLE = 3;
    localparam int IRQ_RESTART  = 4;

    typedef struct packed {
        logic       enable;
        logic [1:0] length;
        logic [4:0] allowance;
    } finder_cfg_t;
endpackage

// ### src/rx_afc_preamble_timeout_ctrl.sv
// Purpose: Receive control bank: correction, offset readout, finder, timeouts, restart
// Assumes: Wishbone classic slave, one wait state, data in bits 7:0
// Notes:   Event inputs are one-cycle pulses from logic on ref_clk_i
// What this block does
// - Writing one to control bit 4 launches one gain control sequence.
// - Writing one to bit 1 in receive zeroes correction; bit reads zero.
// - With auto correction and bit 0 set, correction zeroes per correction phase.
// - Correction is 16-bit two's complement; each byte write replaces only its own byte.
// - Measured offset reported as two's complement count, low byte bits 7:0.
// - Finder runs when bit 7 set; gain phase overrides it.
// - Finder length: 00 one, 01 two, 10 three bytes, 11 reserved.
// - Finder tolerates up to bits 4:0 chip errors, four chips per bit.
// - No signal strength event within count*16 bits raises timeout; 0 disables.
// - No preamble event within count*16 bits raises timeout; 0 disables.
// - No sync match within count*16 bits raises timeout; 0 disables.
// - Restart waits an extra delay of count*4 bit periods.
// - Restart select: 00 off, 01 no relock wait, 10 after relock, 11 reserved.
//
// Chosen here: the Wishbone register port.
`timescale 1ns/1ps
module rx_afc_preamble_timeout_ctrl #(
    parameter int BIT_CYCLES = rx_ctrl_pkg::BIT_CYCLES_DFLT // Clocks per bit
) (
    input  wire logic        ref_clk_i,          // 250 MHz device clock
    input  wire logic        reset_i,            // Async reset, high
    input  wire logic        cyc_i,              // Wishbone cycle
    input  wire logic        stb_i,              // Wishbone strobe
    input  wire logic        we_i,               // Wishbone write
    input  wire logic [7:0]  adr_i,              // Byte address
    input  wire logic [3:0]  sel_i,              // Byte selects
    input  wire logic [31:0] dat_i,              // Write data
    output logic      [31:0] dat_o,              // Read data
    output logic             ack_o,              // Wishbone ack
    input  wire logic        rssi_event_i,       // Signal strength event
    input  wire logic        sync_match_event_i, // Sync word match
    input  wire logic        chip_i,             // Received chip
    input  wire logic        chip_valid_i,       // Chip strobe
    input  wire logic        agc_phase_i,        // Startup or gain phase
    input  wire logic        afc_phase_start_i,  // Auto correction phase start
    input  wire logic [15:0] meas_offset_i,      // Measured offset count
    input  wire logic        meas_valid_i,       // Measurement strobe
    input  wire logic        packet_valid_i,     // Valid packet received
    input  wire logic        pll_locked_i,       // Synthesizer locked
    output logic             gain_control_start_o, // Gain sequence pulse
    output logic      [15:0] freq_correction_o,  // Applied correction
    output logic             rx_active_o,        // Receive mode on
    output logic             preamble_event_o,   // Preamble found pulse
    output logic             timeout_o,          // Timeout pulse
    output logic             restart_o,          // Receiver restart pulse
    output logic             irq_o               // Level interrupt
);
    localparam int IW = rx_ctrl_pkg::IRQ_W;

    if (BIT_CYCLES < 2 || BIT_CYCLES > 65536) begin : g_chk
        $error("BIT_CYCLES out of range");
    end

    typedef enum logic [1:0] {R_IDLE, R_WAIT, R_LOCK} rst_state_t;

    // Register file state
    logic [15:0] corr_q, corr_d, fei_q, fei_d;
    logic [7:0]  shadow_q, shadow_d, pre_q, pre_d, dly_q, dly_d;
    logic [2:0][7:0] lim_q, lim_d;
    logic [1:0]  sel_q, sel_d, rxc_q, rxc_d;
    logic        rsvd_q, rsvd_d, autoz_q, autoz_d, agc_d;
    logic [IW-1:0] stat_q, stat_d, mask_q, mask_d, ev_set;
    logic [31:0] dat_d;
    logic        ack_d, acc, wr, rd, irq_d;
    logic [7:0]  rdata;
    logic [5:0]  idx;

    // Timing and event state
    logic [15:0] div_q, div_d;
    logic [3:0]  u16_q, u16_d;
    logic        bit_tick, tick16, rx_prev_q, rx_enter;
    logic [2:0]  run_q, run_d, fire, awaited;
    logic [2:0][7:0] tcnt_q, tcnt_d;
    logic        to_d;
    rst_state_t  rs_q, rs_d;
    logic [9:0]  dcnt_q, dcnt_d, dtarget;
    logic        restart_d;
    rx_ctrl_pkg::finder_cfg_t fcfg;

    assign fcfg = pre_q;
    assign idx  = adr_i[7:2];
    assign acc  = cyc_i && stb_i && !ack_o;
    assign wr   = acc && we_i && sel_i[0];
    assign rd   = acc && !we_i;

    rx_preamble_finder u_finder (
        .ref_clk_i    (ref_clk_i),
        .reset_i      (reset_i),
        .cfg_i        (fcfg),
        .agc_phase_i  (agc_phase_i),
        .chip_i       (chip_i),
        .chip_valid_i (chip_valid_i),
        .event_o      (preamble_event_o)
    );

    // Bit period and 16-bit-period enables, aligned to receive entry
    always_comb begin
        rx_enter = (rxc_q[rx_ctrl_pkg::RX_EN_BIT] && !rx_prev_q) || restart_o;
        bit_tick = div_q == 16'(BIT_CYCLES - 1);
        tick16   = bit_tick && u16_q == 4'(rx_ctrl_pkg::TIMEOUT_UNIT_BITS - 1);
        div_d    = bit_tick ? 16'h0 : div_q + 16'h1;
        u16_d    = bit_tick ? u16_q + 4'h1 : u16_q;
        if (rx_enter) begin
            div_d = 16'h0;
            u16_d = 4'h0;
        end
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            div_q     <= 16'h0;
            u16_q     <= 4'h0;
            rx_prev_q <= 1'b0;
        end else begin
            div_q     <= div_d;
            u16_q     <= u16_d;
            rx_prev_q <= rxc_q[rx_ctrl_pkg::RX_EN_BIT];
        end
    end

    // Three receive timeouts share one loop
    assign awaited = {sync_match_event_i, preamble_event_o, rssi_event_i};

    for (genvar i = 0; i < 3; i++) begin : g_to
        always_comb begin
            run_d[i]  = run_q[i];
            tcnt_d[i] = tcnt_q[i];
            fire[i]   = 1'b0;
            if (rx_enter) begin
                run_d[i]  = lim_q[i] != 8'h0;
                tcnt_d[i] = 8'h0;
            end else if (!rxc_q[rx_ctrl_pkg::RX_EN_BIT] || awaited[i]) begin
                run_d[i] = 1'b0;
            end else if (run_q[i] && tick16) begin
                tcnt_d[i] = tcnt_q[i] + 8'h1;
                if (tcnt_q[i] + 8'h1 == lim_q[i]) begin
                    fire[i]  = 1'b1;
                    run_d[i] = 1'b0;
                end
            end
        end

        always_ff @(posedge ref_clk_i or posedge reset_i) begin
            if (reset_i) begin
                run_q[i]  <= 1'b0;
                tcnt_q[i] <= 8'h0;
            end else begin
                run_q[i]  <= run_d[i];
                tcnt_q[i] <= tcnt_d[i];
            end
        end
    end

    // Automatic receiver restart after a valid packet
    always_comb begin
        rs_d      = rs_q;
        dcnt_d    = dcnt_q;
        restart_d = 1'b0;
        dtarget   = 10'(dly_q) * 10'(rx_ctrl_pkg::DELAY_UNIT_BITS);
        case (rs_q)
            R_IDLE: begin
                if (packet_valid_i && rxc_q[rx_ctrl_pkg::RX_EN_BIT]
                    && (sel_q == rx_ctrl_pkg::RESTART_NOLOCK
                        || sel_q == rx_ctrl_pkg::RESTART_LOCK)) begin
                    rs_d   = R_WAIT;
                    dcnt_d = 10'h0;
                end
            end
            R_WAIT: begin
                if (dcnt_q == dtarget) begin
                    if (sel_q == rx_ctrl_pkg::RESTART_LOCK) begin
                        rs_d = R_LOCK;
                    end else begin
                        restart_d = 1'b1;
                        rs_d      = R_IDLE;
                    end
                end else if (bit_tick) begin
                    dcnt_d = dcnt_q + 10'h1;
                end
            end
            R_LOCK: begin
                if (pll_locked_i) begin
                    restart_d = 1'b1;
                    rs_d      = R_IDLE;
                end
            end
            default: rs_d = R_IDLE;
        endcase
        if (!rxc_q[rx_ctrl_pkg::RX_EN_BIT]) begin
            rs_d      = R_IDLE;
            restart_d = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            rs_q      <= R_IDLE;
            dcnt_q    <= 10'h0;
            restart_o <= 1'b0;
        end else begin
            rs_q      <= rs_d;
            dcnt_q    <= dcnt_d;
            restart_o <= restart_d;
        end
    end

    // Register file and bus slave
    always_comb begin
        corr_d   = corr_q;
        fei_d    = meas_valid_i ? meas_offset_i : fei_q;
        shadow_d = shadow_q;
        pre_d    = pre_q;
        lim_d    = lim_q;
        dly_d    = dly_q;
        sel_d    = sel_q;
        rxc_d    = rxc_q;
        rsvd_d   = rsvd_q;
        autoz_d  = autoz_q;
        mask_d   = mask_q;
        agc_d    = 1'b0;
        ack_d    = acc;
        rdata    = 8'h0;
        // Auto zero first so a same-cycle software write still lands
        if (afc_phase_start_i && rxc_q[rx_ctrl_pkg::AUTO_CORR_BIT] && autoz_q) begin
            corr_d = 16'h0;
        end
        case (idx)
            rx_ctrl_pkg::IDX_CORR_CTRL: rdata = {4'h0, rsvd_q, 2'h0, autoz_q};
            rx_ctrl_pkg::IDX_CORR_HI:   rdata = corr_q[15:8];
            rx_ctrl_pkg::IDX_CORR_LO:   rdata = corr_q[7:0];
            rx_ctrl_pkg::IDX_FEI_HI:    rdata = fei_q[15:8];
            rx_ctrl_pkg::IDX_FEI_LO:    rdata = shadow_q;
            rx_ctrl_pkg::IDX_PRE_CFG:   rdata = pre_q;
            rx_ctrl_pkg::IDX_TO_RSSI:   rdata = lim_q[0];
            rx_ctrl_pkg::IDX_TO_PRE:    rdata = lim_q[1];
            rx_ctrl_pkg::IDX_TO_SYNC:   rdata = lim_q[2];
            rx_ctrl_pkg::IDX_RST_DLY:   rdata = dly_q;
            rx_ctrl_pkg::IDX_RST_SEL:   rdata = {sel_q, 6'h0};
            rx_ctrl_pkg::IDX_RX_CTRL:   rdata = {6'h0, rxc_q};
            rx_ctrl_pkg::IDX_IRQ_STAT:  rdata = 8'(stat_q);
            rx_ctrl_pkg::IDX_IRQ_MASK:  rdata = 8'(mask_q);
            default:                    rdata = 8'h0;
        endcase
        // Latch low byte on high read so the pair stays coherent
        if (rd && idx == rx_ctrl_pkg::IDX_FEI_HI) begin
            shadow_d = fei_q[7:0];
        end
        if (wr) begin
            case (idx)
                rx_ctrl_pkg::IDX_CORR_CTRL: begin
                    agc_d   = dat_i[rx_ctrl_pkg::CTRL_AGC_BIT];
                    rsvd_d  = dat_i[rx_ctrl_pkg::CTRL_RSVD_BIT];
                    autoz_d = dat_i[rx_ctrl_pkg::CTRL_AUTOZ_BIT];
                    if (dat_i[rx_ctrl_pkg::CTRL_CLR_BIT] && rxc_q[rx_ctrl_pkg::RX_EN_BIT]) begin
                        corr_d = 16'h0;
                    end
                end
                rx_ctrl_pkg::IDX_CORR_HI:  corr_d[15:8] = dat_i[7:0];
                rx_ctrl_pkg::IDX_CORR_LO:  corr_d[7:0]  = dat_i[7:0];
                rx_ctrl_pkg::IDX_PRE_CFG:  pre_d    = dat_i[7:0];
                rx_ctrl_pkg::IDX_TO_RSSI:  lim_d[0] = dat_i[7:0];
                rx_ctrl_pkg::IDX_TO_PRE:   lim_d[1] = dat_i[7:0];
                rx_ctrl_pkg::IDX_TO_SYNC:  lim_d[2] = dat_i[7:0];
                rx_ctrl_pkg::IDX_RST_DLY:  dly_d    = dat_i[7:0];
                rx_ctrl_pkg::IDX_RST_SEL:  sel_d    = dat_i[7:6];
                rx_ctrl_pkg::IDX_RX_CTRL:  rxc_d    = dat_i[1:0];
                rx_ctrl_pkg::IDX_IRQ_MASK: mask_d   = dat_i[IW-1:0];
                default: ;
            endcase
        end
        dat_d  = rd ? {24'h0, rdata} : 32'h0;
        ev_set = {restart_d, preamble_event_o, fire};
        // Read clears, but an event in the same cycle still sets
        stat_d = ((rd && idx == rx_ctrl_pkg::IDX_IRQ_STAT) ? '0 : stat_q) | ev_set;
        irq_d  = |(stat_d & mask_d);
        to_d   = |fire;
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            corr_q   <= 16'h0;
            fei_q    <= 16'h0;
            shadow_q <= 8'h0;
            pre_q    <= rx_ctrl_pkg::PRE_CFG_RST;
            lim_q    <= '0;
            dly_q    <= 8'h0;
            sel_q    <= rx_ctrl_pkg::RST_SEL_RST;
            rxc_q    <= 2'h0;
            rsvd_q   <= 1'b0;
            autoz_q  <= 1'b0;
            stat_q   <= '0;
            mask_q   <= '0;
            dat_o    <= 32'h0;
            ack_o    <= 1'b0;
            irq_o    <= 1'b0;
            timeout_o            <= 1'b0;
            gain_control_start_o <= 1'b0;
            freq_correction_o    <= 16'h0;
            rx_active_o          <= 1'b0;
        end else begin
            corr_q   <= corr_d;
            fei_q    <= fei_d;
            shadow_q <= shadow_d;
            pre_q    <= pre_d;
            lim_q    <= lim_d;
            dly_q    <= dly_d;
            sel_q    <= sel_d;
            rxc_q    <= rxc_d;
            rsvd_q   <= rsvd_d;
            autoz_q  <= autoz_d;
            stat_q   <= stat_d;
            mask_q   <= mask_d;
            dat_o    <= dat_d;
            ack_o    <= ack_d;
            irq_o    <= irq_d;
            timeout_o            <= to_d;
            gain_control_start_o <= agc_d;
            freq_correction_o    <= corr_d;
            rx_active_o          <= rxc_d[rx_ctrl_pkg::RX_EN_BIT];
        end
    end

    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);

    a_agc_pulse: assert property (
        wr && idx == rx_ctrl_pkg::IDX_CORR_CTRL && dat_i[4] |=> gain_control_start_o ##1
        !gain_control_start_o) else $error("gain trigger not a single pulse");
    a_clear_zero: assert property (
        wr && idx == rx_ctrl_pkg::IDX_CORR_CTRL && dat_i[1] && rx_active_o
        && !afc_phase_start_i |=> freq_correction_o == 16'h0)
        else $error("correction not cleared");
    a_clear_reads: assert property (
        ack_o && $past(rd && idx == rx_ctrl_pkg::IDX_CORR_CTRL) |-> !dat_o[1])
        else $error("clear bit read as one");
    a_auto_zero: assert property (
        afc_phase_start_i && rxc_q[1] && autoz_q && !wr |=> freq_correction_o == 16'h0)
        else $error("auto zero missed");
    a_corr_high: assert property (
        wr && idx == rx_ctrl_pkg::IDX_CORR_HI |=> freq_correction_o[15:8] == $past(dat_i[7:0]))
        else $error("high byte write lost");
    a_fei_pair: assert property (
        rd && idx == rx_ctrl_pkg::IDX_FEI_HI |=> shadow_q == $past(fei_q[7:0]))
        else $error("offset low byte not paired");
    a_to_disabled: assert property (
        lim_q[0] == 8'h0 && !rx_enter |=> !run_q[0] || $past(run_q[0]))
        else $error("disabled timeout started");
    a_to_fire: assert property (
        fire[1] |-> run_q[1] && tick16 && tcnt_q[1] + 8'h1 == lim_q[1] ##1 timeout_o)
        else $error("preamble timeout at wrong count");
    a_restart_off: assert property (
        rs_q == R_IDLE && sel_q == rx_ctrl_pkg::RESTART_OFF |=> rs_q == R_IDLE)
        else $error("restart armed while off");
    a_restart_lock: assert property (
        rs_q == R_LOCK && !pll_locked_i |=> !restart_o)
        else $error("restart before relock");
endmodule

// ### src/rx_preamble_finder.sv
// Purpose: Preamble finder over a window of received chips
// Assumes: One chip per chip_valid_i pulse, same clock domain
// Notes:   First chip of a window sets the expected polarity
`timescale 1ns/1ps
module rx_preamble_finder (
    input  wire logic                      ref_clk_i,    // Device clock
    input  wire logic                      reset_i,      // Async reset, high
    input  wire rx_ctrl_pkg::finder_cfg_t  cfg_i,        // Finder settings
    input  wire logic                      agc_phase_i,  // Startup or gain phase
    input  wire logic                      chip_i,       // Chip value
    input  wire logic                      chip_valid_i, // Chip strobe
    output logic                           event_o       // Preamble found pulse
);
    logic [6:0] cnt_q, cnt_d, err_q, err_d, err_n, last, bit_idx;
    logic       first_q, first_d, ev_d, run, expect_v;

    always_comb begin
        run      = cfg_i.enable && !agc_phase_i
                   && cfg_i.length != rx_ctrl_pkg::PRE_LEN_RSVD;
        last     = 7'(({5'h0, cfg_i.length} + 7'h1)
                   * 7'(rx_ctrl_pkg::CHIPS_PER_BIT * rx_ctrl_pkg::BITS_PER_BYTE)) - 7'h1;
        bit_idx  = cnt_q / 7'(rx_ctrl_pkg::CHIPS_PER_BIT);
        expect_v = (cnt_q == 7'h0) ? chip_i : (first_q ^ bit_idx[0]);
        err_n    = err_q + {6'h0, chip_i != expect_v};
        cnt_d    = cnt_q;
        err_d    = err_q;
        first_d  = first_q;
        ev_d     = 1'b0;
        if (!run) begin
            cnt_d = 7'h0;
            err_d = 7'h0;
        end else if (chip_valid_i) begin
            if (cnt_q == 7'h0) begin
                first_d = chip_i;
            end
            if (cnt_q == last) begin
                ev_d  = err_n <= {2'h0, cfg_i.allowance};
                cnt_d = 7'h0;
                err_d = 7'h0;
            end else begin
                cnt_d = cnt_q + 7'h1;
                err_d = err_n;
            end
        end
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            cnt_q   <= 7'h0;
            err_q   <= 7'h0;
            first_q <= 1'b0;
            event_o <= 1'b0;
        end else begin
            cnt_q   <= cnt_d;
            err_q   <= err_d;
            first_q <= first_d;
            event_o <= ev_d;
        end
    end

    a_finder_off: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (!cfg_i.enable || agc_phase_i) |=> !event_o)
        else $error("preamble event while finder disabled");
endmodule

// ### verif/rx_afc_preamble_timeout_ctrl_bench.sv
// Purpose: Self-checking bench for the receive control bank
// Assumes: BIT_CYCLES of 4, so one timeout unit is 64 clocks
// Notes:   Time windows leave a few clocks of pipeline slack
`timescale 1ns/1ps
module rx_afc_preamble_timeout_ctrl_bench;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, rssi = 1'b0, chip = 1'b0, chv = 1'b0;
    logic        agc = 1'b0, afc = 1'b0, mv = 1'b0, pkt = 1'b0, lock = 1'b1, sync = 1'b0;
    logic [7:0]  adr = 8'h00, rd;
    logic [31:0] wd = 32'h0;
    logic [15:0] moff = 16'h0;
    wire  [31:0] dat;
    wire  [15:0] fc;
    wire         ack, gcs, rxa, pre, tout, rso, irq;
    int          n_errors = 0, compares = 0, cycles = 0, g_n = 0, t_n = 0, p_n = 0, r_n = 0, t0;
    // Rows: write flag, index, write data, expected read
    logic [22:0] rows [10] = '{{1'b0, rx_ctrl_pkg::IDX_PRE_CFG, 8'h00, 8'haa},
        {1'b0, rx_ctrl_pkg::IDX_RST_SEL, 8'h00, 8'h80}, {1'b0, rx_ctrl_pkg::IDX_TO_RSSI, 16'h0},
        {1'b0, rx_ctrl_pkg::IDX_CORR_HI, 16'h0}, {1'b1, rx_ctrl_pkg::IDX_TO_PRE, 16'h5a00},
        {1'b0, rx_ctrl_pkg::IDX_TO_PRE, 16'h005a}, {1'b1, rx_ctrl_pkg::IDX_RST_DLY, 16'ha500},
        {1'b0, rx_ctrl_pkg::IDX_RST_DLY, 16'h00a5}, {1'b1, 6'h3f, 16'h7700}, {1'b0, 6'h3f, 16'h0}};
    rx_afc_preamble_timeout_ctrl #(.BIT_CYCLES(4)) u_rx_afc_preamble_timeout_ctrl (
        .ref_clk_i(clk), .reset_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
        .sel_i(4'h1), .dat_i(wd), .dat_o(dat), .ack_o(ack), .rssi_event_i(rssi),
        .sync_match_event_i(sync), .chip_i(chip), .chip_valid_i(chv), .agc_phase_i(agc),
        .afc_phase_start_i(afc), .meas_offset_i(moff), .meas_valid_i(mv),
        .packet_valid_i(pkt), .pll_locked_i(lock), .gain_control_start_o(gcs),
        .freq_correction_o(fc), .rx_active_o(rxa), .preamble_event_o(pre), .timeout_o(tout),
        .restart_o(rso), .irq_o(irq));
    always #2 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        g_n += int'(gcs === 1'b1);
        t_n += int'(tout === 1'b1);
        p_n += int'(pre === 1'b1);
        r_n += int'(rso === 1'b1);
        if (cycles == 8000) begin
            n_errors++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("errors=%0d compares=%0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Classic cycle; request held until ack is seen at an edge
    task automatic wb(input logic w, input logic [5:0] ix, input logic [7:0] d);
        @(posedge clk);
        {cyc, stb, we, adr, wd} <= {1'b1, 1'b1, w, ix, 2'b00, 24'h0, d};
        @(posedge clk);
        while (ack !== 1'b1) @(posedge clk);
        rd = dat[7:0];
        {cyc, stb} <= 2'b00;
    endtask
    // Four chips per bit, bits alternate; one chip error per 96 chips
    task automatic fd(input logic [7:0] c, input logic a, input logic er, input logic e);
        int p0;
        wb(1'b1, rx_ctrl_pkg::IDX_PRE_CFG, c);
        agc <= a;
        p0 = p_n;
        for (int i = 0; i < 192; i++) begin
            @(posedge clk);
            {chip, chv} <= {i[2] ^ (er && i % 96 == 5), 1'b1};
        end
        @(posedge clk);
        {chv, agc} <= 2'b00;
        repeat (4) @(posedge clk);
        chk(16'(p_n != p0), 16'(e));
    endtask
    task automatic tmo(input logic [5:0] ix, input int b);
        t0 = t_n;
        wb(1'b1, ix, 8'h01);
        wb(1'b1, rx_ctrl_pkg::IDX_RX_CTRL, 8'h01);
        repeat (58) @(posedge clk);
        chk(16'(t_n - t0), 16'h0);
        repeat (14) @(posedge clk);
        chk(16'(t_n - t0), 16'h1);
        chk(16'(irq), 16'h1);
        wb(1'b0, rx_ctrl_pkg::IDX_IRQ_STAT, 8'h00);
        chk(16'(rd), 16'h1 << b);
        wb(1'b1, ix, 8'h00);
        wb(1'b1, rx_ctrl_pkg::IDX_RX_CTRL, 8'h00);
        chk(16'(irq), 16'h0);
    endtask
    task automatic rs(input logic [7:0] s, input logic [15:0] e);
        wb(1'b1, rx_ctrl_pkg::IDX_RST_SEL, s);
        t0 = r_n;
        @(posedge clk) pkt <= 1'b1;
        @(posedge clk) pkt <= 1'b0;
        repeat (24) @(posedge clk);
        chk(16'(r_n - t0), 16'h0);
        repeat (20) @(posedge clk);
        chk(16'(r_n - t0), e);
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        foreach (rows[i]) begin
            wb(rows[i][22], rows[i][21:16], rows[i][15:8]);
            if (!rows[i][22]) chk(16'(rd), 16'(rows[i][7:0]));
        end
        wb(1'b1, rx_ctrl_pkg::IDX_CORR_CTRL, 8'h10);
        repeat (2) @(posedge clk);
        chk(16'(g_n), 16'h1);
        wb(1'b1, rx_ctrl_pkg::IDX_CORR_HI, 8'h92);
        wb(1'b1, rx_ctrl_pkg::IDX_CORR_LO, 8'h34);
        chk(fc, 16'h9234);
        wb(1'b1, rx_ctrl_pkg::IDX_RX_CTRL, 8'h03);
        chk(16'(rxa), 16'h1);
        wb(1'b1, rx_ctrl_pkg::IDX_CORR_CTRL, 8'h02);
        chk(fc, 16'h0);
        wb(1'b0, rx_ctrl_pkg::IDX_CORR_CTRL, 8'h00);
        chk(16'(rd), 16'h0);
        wb(1'b1, rx_ctrl_pkg::IDX_CORR_CTRL, 8'h01);
        wb(1'b1, rx_ctrl_pkg::IDX_CORR_LO, 8'h55);
        @(posedge clk) {afc, moff, mv} <= {1'b1, 16'hbe5a, 1'b1};
        @(posedge clk) {afc, moff, mv} <= {1'b0, 16'h0101, 1'b0};
        repeat (2) @(posedge clk);
        chk(fc, 16'h0);
        wb(1'b0, rx_ctrl_pkg::IDX_FEI_HI, 8'h00);
        chk(16'(rd), 16'hbe);
        @(posedge clk) mv <= 1'b1;
        @(posedge clk) mv <= 1'b0;
        wb(1'b0, rx_ctrl_pkg::IDX_FEI_LO, 8'h00);
        chk(16'(rd), 16'h5a);
        wb(1'b1, rx_ctrl_pkg::IDX_RX_CTRL, 8'h00);
        wb(1'b1, rx_ctrl_pkg::IDX_IRQ_MASK, 8'h1f);
        tmo(rx_ctrl_pkg::IDX_TO_RSSI, 0);
        tmo(rx_ctrl_pkg::IDX_TO_PRE, 1);
        tmo(rx_ctrl_pkg::IDX_TO_SYNC, 2);
        wb(1'b1, rx_ctrl_pkg::IDX_TO_RSSI, 8'h01);
        wb(1'b1, rx_ctrl_pkg::IDX_TO_SYNC, 8'h01);
        wb(1'b1, rx_ctrl_pkg::IDX_RX_CTRL, 8'h01);
        t0 = t_n;
        @(posedge clk) {rssi, sync} <= 2'b11;
        @(posedge clk) {rssi, sync} <= 2'b00;
        repeat (90) @(posedge clk);
        chk(16'(t_n - t0), 16'h0);
        wb(1'b1, rx_ctrl_pkg::IDX_TO_RSSI, 8'h00);
        wb(1'b1, rx_ctrl_pkg::IDX_TO_SYNC, 8'h00);
        fd(8'h80, 1'b0, 1'b0, 1'b1);
        fd(8'ha0, 1'b0, 1'b0, 1'b1);
        fd(8'hc0, 1'b0, 1'b1, 1'b0);
        fd(8'hc1, 1'b0, 1'b1, 1'b1);
        fd(8'he0, 1'b0, 1'b0, 1'b0);
        fd(8'h80, 1'b1, 1'b0, 1'b0);
        fd(8'h00, 1'b0, 1'b0, 1'b0);
        wb(1'b1, rx_ctrl_pkg::IDX_RST_DLY, 8'h02);
        rs(8'h40, 16'h1);
        rs(8'h80, 16'h1);
        rs(8'h00, 16'h0);
        lock <= 1'b0;
        rs(8'h80, 16'h0);
        wb(1'b1, rx_ctrl_pkg::IDX_CORR_HI, 8'h12);
        chk(fc, 16'h1200);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        chk(fc, 16'h0);
        chk(16'(rxa), 16'h0);
        wb(1'b0, rx_ctrl_pkg::IDX_PRE_CFG, 8'h00);
        chk(16'(rd), 16'haa);
        stop_test();
    end
endmodule
